// ==== common/dms_map.vh ====
/*
 * Register map, field positions, reset values and source codes of the
 * data signal modulator source selection block.
 * Assumes a 32-bit AXI4-Lite bus with one register per aligned word.
 */
`ifndef DMS_MAP_VH
`define DMS_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define DMS_ADDR_W           5
`define DMS_OFF_CTRL         5'h00
`define DMS_OFF_SRC          5'h04
`define DMS_OFF_CARH         5'h08
`define DMS_OFF_CARL         5'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DMS_CTRL_EN_BIT      7
`define DMS_CTRL_OINV_BIT    4
`define DMS_CTRL_OUT_BIT     3
`define DMS_CTRL_SWBIT_BIT   0
`define DMS_CAR_INV_BIT      6
`define DMS_CAR_SYNC_BIT     5
`define DMS_SEL_MSB          3
`define DMS_SEL_LSB          0

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define DMS_CTRL_RESET       1'b0
`define DMS_SEL_SW_BIT       4'h0
`define DMS_SEL_GROUND       4'h0
`define DMS_SEL_RESERVED     4'h9
`define DMS_RESP_OKAY        2'b00
`define DMS_RESP_SLVERR      2'b10

`endif

// ==== hw/dms_modulator.v ====
/*
 * Data signal modulator: modulation source select, high and low carrier
 * select, carrier polarity and falling-edge synchronisation, output
 * polarity, and an AXI4-Lite register slave.
 * Assumes peripheral sources run on clk; pin and clock-type sources are
 * asynchronous and are synchronised here.
 */
`timescale 1ns/100ps
`default_nettype none
`include "dms_map.vh"

// Functional notes
// - Source code 0 uses software bit, code 1 the routed modulation pin.
// - Codes 2 and 3 pick capture units one and two, pulse-width mode.
// - Codes 4,5 pick pulse generators five, six; 6,7 comparators.
// - Codes 8,9 serial outs, 10 async transmit, 11 numeric oscillator.
// - Codes 12 to 15 pick logic cells one to four, all selectors.
// - High carrier: 0 ground, 1,2 carrier pins, 3 reference clock.
// - High carrier 4,5 capture units, 6,7 pulse generators, 8 oscillator.
// - High carrier 9 reserved, 10 system clock, 11 fast oscillator.
// - Low carrier selector uses the same code assignment as high.
// - High carrier invert bit 6 inverts selected high carrier.
// - Low carrier invert bit 6 inverts selected low carrier.
// - High sync bit 5 delays leaving high carrier to its falling edge.
// - Low sync bit 5 delays leaving low carrier to its falling edge.
// - Unimplemented bits of source and carrier registers read zero.
// - Selector fields start unknown and survive all later resets.
// - Disabled module forces ground carriers and software bit source.
// - Leaving synced carrier: unsynced other starts at once, synced other waits for its fall; left one ends at fall.
// - Output invert bit 4 inverts output, idle level high.
// - Read-only bit 3 of control shows the current modulated output.
module dms_modulator (
    // Clock and reset
    input  wire                   clk,
    input  wire                   reset_n,
    // AXI4-Lite write address
    input  wire [`DMS_ADDR_W-1:0] s_axi_awaddr,
    input  wire                   s_axi_awvalid,
    output reg                    s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0]            s_axi_wdata,
    input  wire [3:0]             s_axi_wstrb,
    input  wire                   s_axi_wvalid,
    output reg                    s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]             s_axi_bresp,
    output reg                    s_axi_bvalid,
    input  wire                   s_axi_bready,
    // AXI4-Lite read address
    input  wire [`DMS_ADDR_W-1:0] s_axi_araddr,
    input  wire                   s_axi_arvalid,
    output reg                    s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0]            s_axi_rdata,
    output reg  [1:0]             s_axi_rresp,
    output reg                    s_axi_rvalid,
    input  wire                   s_axi_rready,
    // Asynchronous pin and clock sources
    input  wire                   mod_pin_route,
    input  wire                   carrier_pin_one_route,
    input  wire                   carrier_pin_two_route,
    input  wire                   reference_clock_out,
    input  wire                   sys_clock_level,
    input  wire                   internal_fast_osc,
    // On-chip peripheral sources
    input  wire                   capture_unit_one,
    input  wire                   capture_unit_two,
    input  wire                   pulse_gen_five,
    input  wire                   pulse_gen_six,
    input  wire                   comparator_one,
    input  wire                   comparator_two,
    input  wire                   serial_out_one,
    input  wire                   serial_out_two,
    input  wire                   async_serial_tx,
    input  wire                   numeric_osc_out,
    input  wire                   logic_cell_one,
    input  wire                   logic_cell_two,
    input  wire                   logic_cell_three,
    input  wire                   logic_cell_four,
    // Modulated output
    output reg                    mod_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    reg                    modulator_enable_r;
    reg                    output_invert_r;
    reg                    software_mod_bit_r;
    reg  [3:0]             mod_source_sel_r;
    reg  [3:0]             hi_carrier_sel_r;
    reg  [3:0]             lo_carrier_sel_r;
    reg                    hi_carrier_invert_r;
    reg                    hi_carrier_sync_en_r;
    reg                    lo_carrier_invert_r;
    reg                    lo_carrier_sync_en_r;

    reg                    aw_full_r;
    reg                    w_full_r;
    reg  [`DMS_ADDR_W-1:0] awaddr_r;
    reg  [31:0]            wdata_r;
    reg  [3:0]             wstrb_r;

    reg  [5:0]             meta_r;
    reg  [5:0]             sync_r;
    reg                    hi_prev_r;
    reg                    lo_prev_r;
    reg                    hi_en_r;
    reg                    lo_en_r;

    wire                   aw_hs;
    wire                   w_hs;
    wire                   aw_have;
    wire                   w_have;
    wire                   do_write;
    wire [`DMS_ADDR_W-1:0] wr_addr;
    wire [31:0]            wr_data;
    wire [3:0]             wr_strb;
    wire                   wr_low;
    wire                   ar_hs;

    wire [15:0]            mod_vec;
    wire [15:0]            car_vec;
    wire [3:0]             mod_eff;
    wire [3:0]             hi_eff;
    wire [3:0]             lo_eff;
    wire                   mod_bit;
    wire                   hi_c;
    wire                   lo_c;
    wire                   hi_fall;
    wire                   lo_fall;
    reg                    hi_en_nxt;
    reg                    lo_en_nxt;
    reg                    mod_out_nxt;
    reg  [31:0]            rdata_nxt;
    reg  [1:0]             rresp_nxt;
    reg  [1:0]             bresp_nxt;

    // ------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------
    assign aw_hs    = s_axi_awvalid & s_axi_awready;
    assign w_hs     = s_axi_wvalid & s_axi_wready;
    assign aw_have  = aw_full_r | aw_hs;
    assign w_have   = w_full_r | w_hs;
    assign do_write = aw_have & w_have & ~s_axi_bvalid;
    assign wr_addr  = aw_full_r ? awaddr_r : s_axi_awaddr;
    assign wr_data  = w_full_r ? wdata_r : s_axi_wdata;
    assign wr_strb  = w_full_r ? wstrb_r : s_axi_wstrb;
    assign wr_low   = do_write & wr_strb[0];

    always @* begin
        if (wr_addr == `DMS_OFF_CTRL) begin
            bresp_nxt = `DMS_RESP_OKAY;
        end else if (wr_addr == `DMS_OFF_SRC) begin
            bresp_nxt = `DMS_RESP_OKAY;
        end else if (wr_addr == `DMS_OFF_CARH) begin
            bresp_nxt = `DMS_RESP_OKAY;
        end else if (wr_addr == `DMS_OFF_CARL) begin
            bresp_nxt = `DMS_RESP_OKAY;
        end else begin
            bresp_nxt = `DMS_RESP_SLVERR;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_full_r     <= 1'b0;
            w_full_r      <= 1'b0;
            awaddr_r      <= {`DMS_ADDR_W{1'b0}};
            wdata_r       <= 32'h0000_0000;
            wstrb_r       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DMS_RESP_OKAY;
        end else begin
            if (aw_hs) begin
                awaddr_r <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_full_r     <= 1'b0;
                w_full_r      <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready  <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= bresp_nxt;
            end else if (s_axi_bvalid) begin
                if (s_axi_bready) begin
                    s_axi_bvalid  <= 1'b0;
                    s_axi_awready <= ~aw_full_r;
                    s_axi_wready  <= ~w_full_r;
                end
            end else begin
                aw_full_r     <= aw_have;
                w_full_r      <= w_have;
                s_axi_awready <= ~aw_have;
                s_axi_wready  <= ~w_have;
            end
        end
    end

    // ------------------------------------------------------------
    // Control register, cleared by every reset
    // ------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            modulator_enable_r <= `DMS_CTRL_RESET;
            output_invert_r    <= `DMS_CTRL_RESET;
            software_mod_bit_r <= `DMS_CTRL_RESET;
        end else if (wr_low && wr_addr == `DMS_OFF_CTRL) begin
            modulator_enable_r <= wr_data[`DMS_CTRL_EN_BIT];
            output_invert_r    <= wr_data[`DMS_CTRL_OINV_BIT];
            software_mod_bit_r <= wr_data[`DMS_CTRL_SWBIT_BIT];
        end
    end

    // ------------------------------------------------------------
    // Selector registers: no reset, contents kept across resets
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (wr_low && wr_addr == `DMS_OFF_SRC) begin
            mod_source_sel_r <= wr_data[`DMS_SEL_MSB:`DMS_SEL_LSB];
        end
        if (wr_low && wr_addr == `DMS_OFF_CARH) begin
            hi_carrier_sel_r     <= wr_data[`DMS_SEL_MSB:`DMS_SEL_LSB];
            hi_carrier_invert_r  <= wr_data[`DMS_CAR_INV_BIT];
            hi_carrier_sync_en_r <= wr_data[`DMS_CAR_SYNC_BIT];
        end
        if (wr_low && wr_addr == `DMS_OFF_CARL) begin
            lo_carrier_sel_r     <= wr_data[`DMS_SEL_MSB:`DMS_SEL_LSB];
            lo_carrier_invert_r  <= wr_data[`DMS_CAR_INV_BIT];
            lo_carrier_sync_en_r <= wr_data[`DMS_CAR_SYNC_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    assign ar_hs = s_axi_arvalid & s_axi_arready;

    always @* begin
        rdata_nxt = 32'h0000_0000;
        rresp_nxt = `DMS_RESP_OKAY;
        if (s_axi_araddr == `DMS_OFF_CTRL) begin
            rdata_nxt[`DMS_CTRL_EN_BIT]    = modulator_enable_r;
            rdata_nxt[`DMS_CTRL_OINV_BIT]  = output_invert_r;
            rdata_nxt[`DMS_CTRL_OUT_BIT]   = mod_out;
            rdata_nxt[`DMS_CTRL_SWBIT_BIT] = software_mod_bit_r;
        end else if (s_axi_araddr == `DMS_OFF_SRC) begin
            rdata_nxt[3:0] = mod_source_sel_r;
        end else if (s_axi_araddr == `DMS_OFF_CARH) begin
            rdata_nxt[3:0]               = hi_carrier_sel_r;
            rdata_nxt[`DMS_CAR_INV_BIT]  = hi_carrier_invert_r;
            rdata_nxt[`DMS_CAR_SYNC_BIT] = hi_carrier_sync_en_r;
        end else if (s_axi_araddr == `DMS_OFF_CARL) begin
            rdata_nxt[3:0]               = lo_carrier_sel_r;
            rdata_nxt[`DMS_CAR_INV_BIT]  = lo_carrier_invert_r;
            rdata_nxt[`DMS_CAR_SYNC_BIT] = lo_carrier_sync_en_r;
        end else begin
            rresp_nxt = `DMS_RESP_SLVERR;
        end
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `DMS_RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdata_nxt;
            s_axi_rresp   <= rresp_nxt;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Synchronisers for pin and clock-type sources
    // ------------------------------------------------------------
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= 6'h00;
            sync_r <= 6'h00;
        end else begin
            meta_r <= {internal_fast_osc, sys_clock_level, reference_clock_out,
                       carrier_pin_two_route, carrier_pin_one_route, mod_pin_route};
            sync_r <= meta_r;
        end
    end

    // ------------------------------------------------------------
    // Source selection, index equals the selector code
    // ------------------------------------------------------------
    assign mod_vec = {logic_cell_four, logic_cell_three,
                      logic_cell_two, logic_cell_one,
                      numeric_osc_out, async_serial_tx,
                      serial_out_two, serial_out_one,
                      comparator_two, comparator_one,
                      pulse_gen_six, pulse_gen_five,
                      capture_unit_two, capture_unit_one,
                      sync_r[0], software_mod_bit_r};

    // Shared by both carriers; code 9 is tied low
    assign car_vec = {logic_cell_four, logic_cell_three,
                      logic_cell_two, logic_cell_one,
                      sync_r[5], sync_r[4], 1'b0,
                      numeric_osc_out, pulse_gen_six, pulse_gen_five,
                      capture_unit_two, capture_unit_one,
                      sync_r[3], sync_r[2], sync_r[1], 1'b0};

    // Disable forces sources without touching stored selections
    assign mod_eff = modulator_enable_r ? mod_source_sel_r : `DMS_SEL_SW_BIT;
    assign hi_eff  = modulator_enable_r ? hi_carrier_sel_r : `DMS_SEL_GROUND;
    assign lo_eff  = modulator_enable_r ? lo_carrier_sel_r : `DMS_SEL_GROUND;

    assign mod_bit = mod_vec[mod_eff];
    // Inversion is applied only while enabled so that idle carriers stay low
    assign hi_c = modulator_enable_r & (car_vec[hi_eff] ^ hi_carrier_invert_r);
    assign lo_c = modulator_enable_r & (car_vec[lo_eff] ^ lo_carrier_invert_r);

    // ------------------------------------------------------------
    // Carrier gating with falling-edge synchronisation
    // ------------------------------------------------------------
    assign hi_fall = hi_prev_r & ~hi_c;
    assign lo_fall = lo_prev_r & ~lo_c;

    always @* begin
        if (mod_bit) begin
            // Entering a synced carrier waits for its falling edge
            hi_en_nxt = hi_en_r | ~hi_carrier_sync_en_r | hi_fall;
            lo_en_nxt = lo_en_r & lo_carrier_sync_en_r & ~lo_fall;
        end else begin
            hi_en_nxt = hi_en_r & hi_carrier_sync_en_r & ~hi_fall;
            lo_en_nxt = lo_en_r | ~lo_carrier_sync_en_r | lo_fall;
        end
        mod_out_nxt = ((hi_c & hi_en_nxt) | (lo_c & lo_en_nxt))
                      ^ output_invert_r;
    end

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hi_prev_r <= 1'b0;
            lo_prev_r <= 1'b0;
            hi_en_r   <= 1'b0;
            lo_en_r   <= 1'b0;
            mod_out   <= 1'b0;
        end else begin
            hi_prev_r <= hi_c;
            lo_prev_r <= lo_c;
            hi_en_r   <= hi_en_nxt;
            lo_en_r   <= lo_en_nxt;
            mod_out   <= mod_out_nxt;
        end
    end

endmodule // dms_modulator

`default_nettype wire

// ==== testbench/dms_monitor.sv ====
/* Checker of the modulator: bus answers, error codes, idle output level.
   Assumes a bind to dms_modulator; it sees that module's ports only. */
`timescale 1ns/100ps
`default_nettype none
`include "dms_map.vh"
module dms_monitor (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Write side of the register bus
    input wire logic [4:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Read side of the register bus
    input wire logic [4:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    // Modulated output
    input wire logic        mod_out
);
    logic en_r;
    logic oinv_r;
    wire  wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire  rd_take = s_axi_arvalid && s_axi_arready;
    // Shadow of enable and output invert, taken from bus writes
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            en_r   <= 1'b0;
            oinv_r <= 1'b0;
        end else if (wr_take && s_axi_awaddr == `DMS_OFF_CTRL && s_axi_wstrb[0]) begin
            en_r   <= s_axi_wdata[`DMS_CTRL_EN_BIT];
            oinv_r <= s_axi_wdata[`DMS_CTRL_OINV_BIT];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_ready_back;
        !s_axi_bvalid ##[0:1] (s_axi_awready && s_axi_wready);
    endsequence
    sequence s_off;
        (!en_r && $stable(oinv_r)) [*3];
    endsequence
    property p_wr_resp; wr_take |=> s_axi_bvalid; endproperty
    property p_wr_err; wr_take && s_axi_awaddr[4] |=> s_axi_bresp == `DMS_RESP_SLVERR; endproperty
    property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    property p_ready_back; s_axi_bvalid && s_axi_bready |=> s_ready_back; endproperty
    property p_rd_resp; rd_take |=> s_axi_rvalid && !s_axi_arready; endproperty
    property p_rd_err;
        rd_take && s_axi_araddr[4] |=> s_axi_rresp == `DMS_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    property p_rd_zero; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    property p_idle_level; s_off |-> mod_out == oinv_r; endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("no write response");
    a_wr_err: assert property (p_wr_err)
        else $error("unmapped write not refused");
    a_b_block: assert property (p_b_block)
        else $error("write ready during response");
    a_ready_back: assert property (p_ready_back)
        else $error("write ready not back");
    a_rd_resp: assert property (p_rd_resp)
        else $error("no read response");
    a_rd_err: assert property (p_rd_err)
        else $error("unmapped read not refused");
    a_rd_zero: assert property (p_rd_zero)
        else $error("unused read bits not zero");
    a_idle_level: assert property (p_idle_level)
        else $error("idle output level wrong");
endmodule // dms_monitor
bind dms_modulator dms_monitor u_dms_monitor (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .mod_out);
`default_nettype wire

// ==== testbench/dms_sources.sv ====
/* Far side: the on-chip sources and pins that feed the modulator.
   Assumes the bench sets the wanted level of each source on pattern. */
`timescale 1ns/100ps
`default_nettype none
module dms_sources (
    // Clock and wanted levels
    input  wire logic        clk,
    input  wire logic [19:0] pattern,
    // One line per source
    output var  logic [19:0] lines
);
    // Levels change just after a clock edge, as on-chip logic does
    always @(posedge clk) begin
        lines <= pattern;
    end
endmodule // dms_sources
`default_nettype wire

// ==== testbench/dms_modulator_bench.sv ====
/* Bench of the modulator: every source and carrier code, polarity, sync,
   enable and register access. Assumes dms_sources feeds the source inputs. */
`timescale 1ns/100ps
`default_nettype none
`include "dms_map.vh"
module dms_modulator_bench;
    logic        clk, reset_n;
    logic [4:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, rd;
    logic [3:0]  s_axi_wstrb, strb;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire         mod_out;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    logic [1:0]  resp;
    logic [19:0] pattern;
    wire  [19:0] src;
    int          fail_count, n_compared, cycles;
    // Source line per code, 5'h1f where nothing is connected
    localparam logic [4:0] MOD_IDX [16] = '{5'h1f, 5'h00, 5'h06, 5'h07, 5'h08, 5'h09,
        5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13};
    localparam logic [4:0] CAR_IDX [16] = '{5'h1f, 5'h01, 5'h02, 5'h03, 5'h06, 5'h07,
        5'h08, 5'h09, 5'h0f, 5'h1f, 5'h04, 5'h05, 5'h10, 5'h11, 5'h12, 5'h13};
    dms_sources u_dms_sources (.clk(clk), .pattern(pattern), .lines(src));
    dms_modulator u_dms_modulator (.clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mod_out,
        .mod_pin_route(src[0]), .carrier_pin_one_route(src[1]), .carrier_pin_two_route(src[2]),
        .reference_clock_out(src[3]), .sys_clock_level(src[4]), .internal_fast_osc(src[5]),
        .capture_unit_one(src[6]), .capture_unit_two(src[7]), .pulse_gen_five(src[8]),
        .pulse_gen_six(src[9]), .comparator_one(src[10]), .comparator_two(src[11]),
        .serial_out_one(src[12]), .serial_out_two(src[13]), .async_serial_tx(src[14]),
        .numeric_osc_out(src[15]), .logic_cell_one(src[16]), .logic_cell_two(src[17]),
        .logic_cell_three(src[18]), .logic_cell_four(src[19]));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus transfer; w picks write or read
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= strb;
        s_axi_awvalid <= w;
        s_axi_wvalid  <= w;
        s_axi_bready  <= w;
        s_axi_arvalid <= !w;
        s_axi_rready  <= !w;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!(w ? s_axi_bvalid : s_axi_rvalid));
        resp = w ? s_axi_bresp : s_axi_rresp;
        rd = s_axi_rdata;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
    endtask
    task automatic pause();
        repeat (5) @(posedge clk);
    endtask
    // k: 0 modulation source, 1 high carrier, 2 low carrier
    task automatic run_row(input int k, input logic [3:0] c);
        logic [4:0] idx;
        idx = (k == 0) ? MOD_IDX[c] : CAR_IDX[c];
        xfer(1, `DMS_OFF_SRC, (k == 0) ? {28'h0, c} : 32'h0);
        xfer(1, `DMS_OFF_CARH, (k == 1) ? {28'h0, c} : ((k == 0) ? 32'h40 : 32'h0));
        xfer(1, `DMS_OFF_CARL, (k == 2) ? {28'h0, c} : 32'h0);
        xfer(1, `DMS_OFF_CTRL, (k == 1) ? 32'h81 : 32'h80);
        pattern <= (idx == 5'h1f) ? 20'h0 : (20'h1 << idx);
        pause();
        chk(mod_out, idx != 5'h1f);
        pattern <= (idx == 5'h1f) ? 20'hfffff : ~(20'h1 << idx);
        pause();
        chk(mod_out, 32'h0);
    endtask
    // Leave a carrier fed by a high logic cell, with or without sync
    task automatic sync_case(input logic [4:0] a, input logic [31:0] cv, input logic sw,
                             input logic s);
        xfer(1, `DMS_OFF_SRC, 32'h0);
        xfer(1, `DMS_OFF_CARH, 32'h0);
        xfer(1, `DMS_OFF_CARL, 32'h0);
        xfer(1, `DMS_OFF_CTRL, 32'h80 | sw);
        xfer(1, a, cv | {26'h0, s, 5'h0});
        pattern <= 20'hf0000;
        pause();
        chk(mod_out, 32'h1);
        xfer(1, `DMS_OFF_CTRL, 32'h80 | !sw);
        pause();
        chk(mod_out, s);
        pattern <= 20'h0;
        pause();
        chk(mod_out, 32'h0);
    endtask
    task complete_run();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        reset_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 46'h0;
        pattern = 20'h0;
        strb = 4'hf;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        xfer(0, `DMS_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        chk(mod_out, 32'h0);
        $display("test reset done");
        for (int k = 0; k < 3; k++)
            for (int c = (k == 0) ? 1 : 0; c < 16; c++)
                run_row(k, c[3:0]);
        $display("test source codes done");
        for (int s = 0; s < 2; s++) begin
            sync_case(`DMS_OFF_CARH, 32'hc, 1'b1, s[0]);
            sync_case(`DMS_OFF_CARL, 32'hd, 1'b0, s[0]);
        end
        $display("test carrier sync done");
        xfer(1, `DMS_OFF_CARL, 32'h40);
        xfer(1, `DMS_OFF_CTRL, 32'h80);
        pause();
        chk(mod_out, 32'h1);
        xfer(0, `DMS_OFF_CTRL, 32'h0);
        chk(rd, 32'h88);
        xfer(1, `DMS_OFF_CTRL, 32'h0);
        pause();
        chk(mod_out, 32'h0);
        xfer(1, `DMS_OFF_CTRL, 32'h10);
        pause();
        chk(mod_out, 32'h1);
        xfer(1, `DMS_OFF_CTRL, 32'h90);
        pause();
        chk(mod_out, 32'h0);
        $display("test enable and polarity done");
        xfer(1, `DMS_OFF_SRC, 32'hffffffff);
        xfer(1, `DMS_OFF_CARH, 32'hffffffff);
        xfer(0, `DMS_OFF_SRC, 32'h0);
        chk(rd, 32'h0f);
        xfer(0, `DMS_OFF_CARH, 32'h0);
        chk(rd, 32'h6f);
        strb = 4'h0;
        xfer(1, `DMS_OFF_SRC, 32'h3);
        strb = 4'hf;
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        xfer(0, `DMS_OFF_SRC, 32'h0);
        chk(rd, 32'h0f);
        xfer(0, `DMS_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        xfer(1, 5'h10, 32'h1);
        chk(resp, `DMS_RESP_SLVERR);
        xfer(0, 5'h1c, 32'h0);
        chk(resp, `DMS_RESP_SLVERR);
        chk(rd, 32'h0);
        $display("test registers done");
        complete_run();
    end
endmodule // dms_modulator_bench
`default_nettype wire
